// ===== rtl/temp_current_calibration_defines.vh
// Purpose: Shared constants for the temperature/current calibration block
// Assumes: 50 MHz system clock, word-organised register space
// Notes:   Offsets are word addresses; every register is 16 bits
`ifndef TEMP_CURRENT_CALIBRATION_DEFINES_VH
`define TEMP_CURRENT_CALIBRATION_DEFINES_VH

// Register word addresses
`define ADDR_TEMPERATURE_RESULT   8'h08
`define ADDR_CURRENT_RESULT       8'h0a
`define ADDR_TEMPERATURE_AVERAGE  8'h16
`define ADDR_TEMPERATURE_EXTREMES 8'h1a
`define ADDR_THERMISTOR_RATIO     8'h27
`define ADDR_TEMPERATURE_GAIN     8'h2c
`define ADDR_TEMPERATURE_OFFSET   8'h2d
`define ADDR_CURRENT_GAIN_TRIM    8'h2e
`define ADDR_CURRENT_OFFSET_TRIM  8'h2f

// Power-on values
`define RST_TEMPERATURE_RESULT    16'h1600
`define RST_TEMPERATURE_AVERAGE   16'h1600
`define RST_TEMPERATURE_EXTREMES  16'h807f
`define RST_THERMISTOR_RATIO      16'h0000
`define RST_TEMPERATURE_GAIN      16'h4000
`define RST_TEMPERATURE_OFFSET    16'h0000
`define RST_CURRENT_GAIN_TRIM     16'h4000
`define RST_CURRENT_OFFSET_TRIM   16'h0000
`define RST_CURRENT_RESULT        16'h0000
`define RESERVED_READ_VALUE       16'h0000

// Extremes field layout
`define EXT_MAX_MSB 15
`define EXT_MAX_LSB 8
`define EXT_MIN_MSB 7
`define EXT_MIN_LSB 0

// Gain scaling: divide by 16384 is an arithmetic shift by 14
`define TRIM_GAIN_SHIFT 14

// Timing
`define CLK_HZ            50000000
`define CLK_PER_US        50
`define TEMP_PERIOD_MS    1400
`define CUR_PERIOD_US     175800
`define PULLUP_SETTLE_US  8000

// Cycle counts at 50 MHz, sized to the 27-bit period timers
`define TEMP_PERIOD_CYCLES 27'd70000000
`define CUR_PERIOD_CYCLES  27'd8790000
`define SETTLE_CYCLES      27'd400000

`endif

// ===== rtl/trim_calc.v
// Purpose: Gain/offset trim: raw * gain / 16384 + 2 * offset, saturated
// Assumes: Raw sample presented as 17-bit signed, trims as 16-bit signed
// Notes:   Purely combinational; the caller registers the result
`include "temp_current_calibration_defines.vh"

module trim_calc (
  input  wire signed [16:0] rawIn,     // Signed or zero-extended sample
  input  wire signed [15:0] gainIn,    // Signed gain, 4000h is unity
  input  wire signed [15:0] offsetIn,  // Signed offset, applied doubled
  output reg  signed [15:0] resultOut  // Saturated 16-bit result
);

  wire signed [32:0] product;   // Full-precision product
  wire signed [18:0] scaled;    // Product divided by 16384
  wire signed [19:0] sum;       // Scaled value plus doubled offset

  assign product = rawIn * gainIn;
  assign scaled  = product[32:`TRIM_GAIN_SHIFT];
  assign sum     = {scaled[18], scaled} + {{3{offsetIn[15]}}, offsetIn, 1'b0};

  // Clamp instead of wrap so a large trim never flips the sign
  always @* begin
    if (sum > 20'sh07fff) begin
      resultOut = 16'sh7fff;
    end else if (sum < -20'sh08000) begin
      resultOut = 16'sh8000;
    end else begin
      resultOut = sum[15:0];
    end
  end

endmodule // trim_calc

// ===== rtl/temp_current_calibration.v
// Purpose: Trims current samples, runs thermistor conversions, converts
//          ratio to temperature, tracks average and 8-bit extremes, and
//          serves the word register space with coherent reads
// Assumes: Converter handshakes and config bits are in the clk domain;
//          the serial front end presents decoded word accesses
// Notes:   Only power-on reset clears registers; inactive mode keeps all
`include "temp_current_calibration_defines.vh"

module temp_current_calibration #(
  parameter [26:0] TEMP_PERIOD_CYC = `TEMP_PERIOD_CYCLES,
  parameter [26:0] CUR_PERIOD_CYC  = `CUR_PERIOD_CYCLES,
  parameter [26:0] SETTLE_CYC      = `SETTLE_CYCLES
) (
  input  wire        clk,                    // 50 MHz system clock
  input  wire        srst,                   // Synchronous power-on reset
  input  wire        activeMode,             // High while not in shutdown
  input  wire        tempMeasureEnable,      // Temperature measure enable
  input  wire        extTempMode,            // Host supplies temperature
  input  wire        thermistorSwitchEnable, // Open bias after conversion
  input  wire        thermistorForceOn,      // Keep bias always closed
  input  wire [3:0]  averagingWindowConfig,  // Average filter shift
  output wire        currentStart,           // Start current conversion
  input  wire        currentDone,            // Current sample valid
  input  wire [15:0] currentRaw,             // Signed raw current sample
  output wire        thermistorBiasPin,      // Bias pin tied to supply
  output wire        ratioStart,             // Start ratio conversion
  input  wire        ratioDone,              // Ratio sample valid
  input  wire [15:0] thermistorSenseInput,   // Ratiometric sample
  input  wire [7:0]  regAddr,                // Word address
  input  wire        regWrite,               // Word write strobe
  input  wire [15:0] regWrData,              // Word write data
  input  wire        regRdMsb,               // Upper byte read begins
  output reg  [15:0] regRdData               // Held read word
);

  // Thermistor sequencer states, one-hot
  localparam [2:0] ST_IDLE    = 3'b001;
  localparam [2:0] ST_SETTLE  = 3'b010;
  localparam [2:0] ST_CONVERT = 3'b100;

  reg  [2:0]  state_q;        // Sequencer state
  reg  [2:0]  state_d;        // Next sequencer state
  reg  [26:0] tempTimer_q;    // Ratio conversion period counter
  reg  [26:0] settleTimer_q;  // Pullup settle counter
  reg  [26:0] curTimer_q;     // Current conversion period counter
  reg         biasOn_q;       // Internal bias switch state
  reg         ratioStart_q;   // One-cycle start to ratio converter
  reg         curStart_q;     // One-cycle start to current converter

  reg  [15:0] ratio_q;        // thermistor_ratio
  reg  [15:0] temperature_q;  // temperature_result
  reg  [15:0] average_q;      // temperature_average
  reg  [15:0] extremes_q;     // temperature_extremes
  reg  [15:0] tempGain_q;     // temperature_gain
  reg  [15:0] tempOffset_q;   // temperature_offset
  reg  [15:0] curGain_q;      // current_gain_trim
  reg  [15:0] curOffset_q;    // current_offset_trim
  reg  [15:0] curRaw_q;       // Last raw current sample
  reg  [15:0] current_q;      // Trimmed current result
  reg         curLoad_q;      // Raw current captured last cycle
  reg         ratioLoad_q;    // Ratio captured last cycle
  reg         tempUpd_q;      // Temperature written last cycle
  reg         seeded_q;       // Average has been seeded

  wire signed [15:0] curTrim;   // Trimmed current
  wire signed [15:0] tempConv;  // Converted temperature
  wire signed [16:0] avgDiff;   // Reading minus average
  wire signed [16:0] avgStep;   // Shifted difference
  wire signed [7:0]  newWhole;  // Whole-degree part of new reading
  wire signed [7:0]  maxNow;    // Current stored maximum
  wire signed [7:0]  minNow;    // Current stored minimum
  wire               tempTick;  // Ratio period elapsed
  wire               runTemp;   // Temperature measurement running
  wire               wrTemp;    // Host writes temperature
  wire               wrExt;     // Host writes extremes
  reg  [15:0]        rdMux;     // Selected read word

  // Current trim path
  trim_calc currentTrim (
    .rawIn     ({curRaw_q[15], curRaw_q}),
    .gainIn    (curGain_q),
    .offsetIn  (curOffset_q),
    .resultOut (curTrim)
  );

  // Ratio is unsigned, so zero-extend before the signed multiply
  trim_calc tempTrim (
    .rawIn     ({1'b0, ratio_q}),
    .gainIn    (tempGain_q),
    .offsetIn  (tempOffset_q),
    .resultOut (tempConv)
  );

  assign runTemp   = activeMode & tempMeasureEnable;
  assign tempTick  = (tempTimer_q == TEMP_PERIOD_CYC - 27'd1);
  assign wrTemp    = regWrite & (regAddr == `ADDR_TEMPERATURE_RESULT);
  assign wrExt     = regWrite & (regAddr == `ADDR_TEMPERATURE_EXTREMES);

  // Force-on overrides the switch; no pullup glitch between conversions
  assign thermistorBiasPin = biasOn_q | thermistorForceOn;
  assign ratioStart        = ratioStart_q;
  assign currentStart      = curStart_q;

  // Current conversion cadence, timer held at zero in shutdown
  always @(posedge clk) begin
    if (srst) begin
      curTimer_q <= 27'd0;
      curStart_q <= 1'b0;
    end else if (!activeMode) begin
      curTimer_q <= 27'd0; // Shutdown keeps last results
      curStart_q <= 1'b0;
    end else if (curTimer_q == CUR_PERIOD_CYC - 27'd1) begin
      curTimer_q <= 27'd0;
      curStart_q <= 1'b1;
    end else begin
      curTimer_q <= curTimer_q + 27'd1;
      curStart_q <= 1'b0;
    end
  end

  // Capture raw current, then register the trimmed value a cycle later
  always @(posedge clk) begin
    if (srst) begin
      curRaw_q  <= `RST_CURRENT_RESULT;
      curLoad_q <= 1'b0;
      current_q <= `RST_CURRENT_RESULT;
    end else begin
      curLoad_q <= currentDone;
      if (currentDone) begin
        curRaw_q <= currentRaw; // Input sample stored as received
      end
      if (curLoad_q) begin
        current_q <= curTrim;
      end
    end
  end

  // Ratio period counter; stopped while disabled or inactive
  always @(posedge clk) begin
    if (srst) begin
      tempTimer_q <= 27'd0;
    end else if (!runTemp || tempTick) begin
      tempTimer_q <= 27'd0;
    end else begin
      tempTimer_q <= tempTimer_q + 27'd1;
    end
  end

  // Sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (runTemp && tempTick) begin
          state_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settleTimer_q == SETTLE_CYC - 27'd1) begin
          state_d = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (ratioDone) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers, bias switch and converter start
  always @(posedge clk) begin
    if (srst) begin
      state_q       <= ST_IDLE;
      settleTimer_q <= 27'd0;
      biasOn_q      <= 1'b0;
      ratioStart_q  <= 1'b0;
    end else begin
      state_q      <= state_d;
      ratioStart_q <= (state_q == ST_SETTLE) && (state_d == ST_CONVERT);
      if (state_q == ST_SETTLE) begin
        settleTimer_q <= settleTimer_q + 27'd1;
      end else begin
        settleTimer_q <= 27'd0;
      end
      if (state_q == ST_IDLE && state_d == ST_SETTLE) begin
        biasOn_q <= 1'b1;
      end else if (state_q == ST_CONVERT && ratioDone &&
                   thermistorSwitchEnable && !thermistorForceOn) begin
        biasOn_q <= 1'b0;
      end
    end
  end

  // Ratio register: written only by a finished conversion
  always @(posedge clk) begin
    if (srst) begin
      ratio_q     <= `RST_THERMISTOR_RATIO;
      ratioLoad_q <= 1'b0;
    end else begin
      ratioLoad_q <= 1'b0;
      if (state_q == ST_CONVERT && ratioDone) begin
        ratio_q     <= thermistorSenseInput;
        ratioLoad_q <= 1'b1;
      end
    end
  end

  // Temperature register: converter result unless the host owns it.
  // A converter update beats a same-cycle host write in normal mode.
  always @(posedge clk) begin
    if (srst) begin
      temperature_q <= `RST_TEMPERATURE_RESULT;
      tempUpd_q     <= 1'b0;
    end else begin
      tempUpd_q <= 1'b0;
      if (ratioLoad_q && !extTempMode && tempMeasureEnable) begin
        temperature_q <= tempConv;
        tempUpd_q     <= 1'b1;
      end else if (wrTemp) begin
        temperature_q <= regWrData;
        tempUpd_q     <= 1'b1;
      end
    end
  end

  // Exponential average; the window config sets the shift
  assign avgDiff = {temperature_q[15], temperature_q} -
                   {average_q[15], average_q};
  assign avgStep = avgDiff >>> averagingWindowConfig;

  always @(posedge clk) begin
    if (srst) begin
      average_q <= `RST_TEMPERATURE_AVERAGE;
      seeded_q  <= 1'b0;
    end else if (tempUpd_q) begin
      seeded_q <= 1'b1;
      if (!seeded_q) begin
        average_q <= temperature_q;
      end else begin
        average_q <= average_q + avgStep[15:0];
      end
    end
  end

  // Extremes compare on the signed whole-degree byte. A host restart in
  // the same cycle as an update is applied first, so the reading lands.
  assign newWhole = temperature_q[15:8];
  assign maxNow   = wrExt ? regWrData[`EXT_MAX_MSB:`EXT_MAX_LSB]
                          : extremes_q[`EXT_MAX_MSB:`EXT_MAX_LSB];
  assign minNow   = wrExt ? regWrData[`EXT_MIN_MSB:`EXT_MIN_LSB]
                          : extremes_q[`EXT_MIN_MSB:`EXT_MIN_LSB];

  always @(posedge clk) begin
    if (srst) begin
      extremes_q <= `RST_TEMPERATURE_EXTREMES;
    end else if (tempUpd_q) begin
      extremes_q[`EXT_MAX_MSB:`EXT_MAX_LSB] <=
        (newWhole > maxNow) ? newWhole : maxNow;
      extremes_q[`EXT_MIN_MSB:`EXT_MIN_LSB] <=
        (newWhole < minNow) ? newWhole : minNow;
    end else if (wrExt) begin
      extremes_q <= regWrData;
    end
  end

  // Host-writable trims; reset values give unity gain, zero offset
  always @(posedge clk) begin
    if (srst) begin
      tempGain_q   <= `RST_TEMPERATURE_GAIN;
      tempOffset_q <= `RST_TEMPERATURE_OFFSET;
      curGain_q    <= `RST_CURRENT_GAIN_TRIM;
      curOffset_q  <= `RST_CURRENT_OFFSET_TRIM;
    end else if (regWrite) begin
      case (regAddr)
        `ADDR_TEMPERATURE_GAIN:    tempGain_q   <= regWrData;
        `ADDR_TEMPERATURE_OFFSET:  tempOffset_q <= regWrData;
        `ADDR_CURRENT_GAIN_TRIM:   curGain_q    <= regWrData;
        `ADDR_CURRENT_OFFSET_TRIM: curOffset_q  <= regWrData;
        default: begin
          // Read-only and reserved words ignore writes
        end
      endcase
    end
  end

  // Read select across the full 8-bit word space
  always @* begin
    case (regAddr)
      `ADDR_TEMPERATURE_RESULT:   rdMux = temperature_q;
      `ADDR_CURRENT_RESULT:       rdMux = current_q;
      `ADDR_TEMPERATURE_AVERAGE:  rdMux = average_q;
      `ADDR_TEMPERATURE_EXTREMES: rdMux = extremes_q;
      `ADDR_THERMISTOR_RATIO:     rdMux = ratio_q;
      `ADDR_TEMPERATURE_GAIN:     rdMux = tempGain_q;
      `ADDR_TEMPERATURE_OFFSET:   rdMux = tempOffset_q;
      `ADDR_CURRENT_GAIN_TRIM:    rdMux = curGain_q;
      `ADDR_CURRENT_OFFSET_TRIM:  rdMux = curOffset_q;
      default:                    rdMux = `RESERVED_READ_VALUE;
    endcase
  end

  // Both bytes captured at the upper-byte read and held until the next,
  // so the lower byte cannot tear against a mid-read update
  always @(posedge clk) begin
    if (srst) begin
      regRdData <= `RESERVED_READ_VALUE;
    end else if (regRdMsb) begin
      regRdData <= rdMux;
    end
  end

endmodule // temp_current_calibration

// ===== sim/converter_model.sv
// Purpose: Far-side converters: current and thermistor ratio samples
// Assumes: One request at a time per converter, answer lag+1 cycles after the start is seen
// Notes:   Data lines toggle outside the valid cycle so stale data shows
module converter_model (
  input  wire logic        clk,
  input  wire logic        currentStart,
  input  wire logic        ratioStart,
  input  wire logic [3:0]  lag,
  input  wire logic [15:0] rawVal,
  input  wire logic [15:0] ratioVal,
  output logic             currentDone,
  output logic             ratioDone,
  output logic [15:0]      currentRaw,
  output logic [15:0]      thermistorSenseInput
);
  timeunit 1ns;
  timeprecision 1ns;
  int curWait = -1; // Cycles left before the current answer
  int ratWait = -1; // Cycles left before the ratio answer
  initial begin
    currentDone = 1'b0;
    ratioDone = 1'b0;
    currentRaw = 16'h0000;
    thermistorSenseInput = 16'h0000;
  end
  // Answer each start once; data is only valid with its done pulse
  always @(posedge clk) begin
    currentDone <= 1'b0;
    ratioDone <= 1'b0;
    currentRaw <= ~currentRaw;
    thermistorSenseInput <= ~thermistorSenseInput;
    if (currentStart) curWait <= lag;
    else if (curWait == 0) begin
      currentDone <= 1'b1;
      currentRaw <= rawVal;
      curWait <= -1;
    end else if (curWait > 0) curWait <= curWait - 1;
    if (ratioStart) ratWait <= lag;
    else if (ratWait == 0) begin
      ratioDone <= 1'b1;
      thermistorSenseInput <= ratioVal;
      ratWait <= -1;
    end else if (ratWait > 0) ratWait <= ratWait - 1;
  end
endmodule // converter_model

// ===== sim/temp_cal_sva.sv
// Purpose: Port-level checks of sequencing, timing and read holding
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Counters are helper logic; periods come from the parameters
module temp_cal_sva #(
  parameter int SETTLE_CYC     = 5,
  parameter int CUR_PERIOD_CYC = 50
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        activeMode,
  input wire logic        thermistorSwitchEnable,
  input wire logic        thermistorForceOn,
  input wire logic        currentStart,
  input wire logic        thermistorBiasPin,
  input wire logic        ratioStart,
  input wire logic        ratioDone,
  input wire logic [7:0]  regAddr,
  input wire logic        regRdMsb,
  input wire logic [15:0] regRdData
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [31:0] curCnt_q;  // Cycles since the last current start
  logic        curSeen_q; // A start was seen since going active
  logic [31:0] biasCnt_q; // Cycles the bias has been on
  logic        conv_q;    // Ratio conversion in flight
  // Shutdown voids the period count, since the timer clears to zero there
  always_ff @(posedge clk) begin
    if (srst || !activeMode) begin
      curSeen_q <= 1'b0;
      curCnt_q <= 32'h0;
    end else if (currentStart) begin
      curSeen_q <= 1'b1;
      curCnt_q <= 32'h0;
    end else curCnt_q <= curCnt_q + 32'h1;
  end
  // Bias on-time and conversion tracking
  always_ff @(posedge clk) begin
    biasCnt_q <= (srst || !thermistorBiasPin) ? 32'h0 : biasCnt_q + 32'h1;
    if (srst) conv_q <= 1'b0;
    else if (ratioStart) conv_q <= 1'b1;
    else if (ratioDone) conv_q <= 1'b0;
  end
  rd_reset_a: assert property (disable iff (1'b0)
    $fell(srst) |-> regRdData == 16'h0000) else $error("read word not clear");
  read_hold_a: assert property (!regRdMsb |=> $stable(regRdData))
    else $error("read word changed");
  reserved_read_a: assert property (regRdMsb && regAddr == 8'h0c
    |=> regRdData == 16'h0000) else $error("reserved read not zero");
  bias_first_a: assert property (ratioStart |-> thermistorBiasPin)
    else $error("sample without bias");
  settle_time_a: assert property (ratioStart
    |-> biasCnt_q >= SETTLE_CYC - 1) else $error("settle too short");
  start_pulse_a: assert property (ratioStart |=> !ratioStart)
    else $error("ratio start too long");
  bias_release_a: assert property (conv_q && ratioDone &&
    thermistorSwitchEnable && !thermistorForceOn |=> !thermistorBiasPin)
    else $error("bias not released");
  force_on_a: assert property (thermistorForceOn |-> thermistorBiasPin)
    else $error("forced bias off");
  cur_period_a: assert property (curSeen_q
    |-> currentStart == (curCnt_q == CUR_PERIOD_CYC - 1))
    else $error("current period wrong");
  quiet_off_a: assert property (!activeMode && !$past(activeMode)
    |-> !currentStart) else $error("start in shutdown");
  cover property (ratioStart);
  cover property (conv_q && ratioDone && !thermistorForceOn);
  cover property (regRdMsb && regAddr == 8'h0c);
endmodule // temp_cal_sva
bind temp_current_calibration temp_cal_sva #(
  .SETTLE_CYC(SETTLE_CYC),
  .CUR_PERIOD_CYC(CUR_PERIOD_CYC)
) temp_cal_sva_inst (.clk, .srst, .activeMode, .thermistorSwitchEnable,
  .thermistorForceOn, .currentStart, .thermistorBiasPin, .ratioStart,
  .ratioDone, .regAddr, .regRdMsb, .regRdData);

// ===== sim/tb.sv
// Purpose: Self-checking bench for the calibration block
// Assumes: Shortened periods; converters modelled by converter_model
// Notes:   Expected values are worked out here from the trim formula
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, srst = 1, activeMode = 1, tempMeasureEnable = 0;
  logic extTempMode = 0, thermistorSwitchEnable = 1, thermistorForceOn = 0;
  logic [3:0] averagingWindowConfig = 4'h4, lag = 4'h2;
  logic [7:0] regAddr = 8'h00;
  logic regWrite = 0, regRdMsb = 0, currentStart, currentDone;
  logic thermistorBiasPin, ratioStart, ratioDone;
  logic [15:0] regWrData = 0, regRdData, currentRaw, thermistorSenseInput;
  logic [15:0] rawVal = 0, ratioVal = 0;
  int miscompares = 0, check_count = 0;
  temp_current_calibration #(.TEMP_PERIOD_CYC(27'd200),
    .CUR_PERIOD_CYC(27'd50), .SETTLE_CYC(27'd5))
  temp_current_calibration_inst (.clk, .srst, .activeMode,
    .tempMeasureEnable, .extTempMode, .thermistorSwitchEnable,
    .thermistorForceOn, .averagingWindowConfig, .currentStart,
    .currentDone, .currentRaw, .thermistorBiasPin, .ratioStart, .ratioDone,
    .thermistorSenseInput, .regAddr, .regWrite, .regWrData, .regRdMsb,
    .regRdData);
  converter_model converter_model_inst (.clk, .currentStart, .ratioStart,
    .lag, .rawVal, .ratioVal, .currentDone, .ratioDone, .currentRaw,
    .thermistorSenseInput);
  always #10 clk = ~clk;
  task automatic check(input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) begin
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
    end
    @(posedge clk) regWrite <= 1'b0;
  endtask
  // Read word is registered one edge after the capture strobe
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk) begin
      regAddr <= a;
      regRdMsb <= 1'b1;
    end
    @(posedge clk) regRdMsb <= 1'b0;
    #1 check(regRdData, exp);
  endtask
  // Bounded wait for a converter answer, then let results settle
  task automatic waitPulse(input bit isRatio);
    int n = 0;
    while ((isRatio ? ratioDone : currentDone) !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) miscompares++;
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [15:0] trimx(logic signed [16:0] r,
                                        logic signed [15:0] g, o);
    longint v;
    v = ((longint'(r) * g) >>> 14) + 2 * longint'(o);
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction
  task automatic t_reset();
    logic [7:0] a[8] = '{8'h08, 8'h16, 8'h1a, 8'h27, 8'h2c, 8'h2d, 8'h2e,
                         8'h2f};
    logic [15:0] v[8] = '{16'h1600, 16'h1600, 16'h807f, 16'h0000,
                          16'h4000, 16'h0000, 16'h4000, 16'h0000};
    for (int i = 0; i < 8; i++) rdchk(a[i], v[i]);
    $display("test reset values done");
  endtask
  // Plain trim, then positive and negative saturation
  task automatic t_current();
    logic [15:0] r[3] = '{16'h1234, 16'h8000, 16'h8000};
    logic [15:0] g[3] = '{16'h2000, 16'h8000, 16'h7fff};
    logic [15:0] o[3] = '{16'h0010, 16'h0000, 16'h8000};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) rawVal <= r[i];
      wr(8'h2e, g[i]);
      wr(8'h2f, o[i]);
      waitPulse(1'b0);
      rdchk(8'h0a, trimx({r[i][15], r[i]}, g[i], o[i]));
    end
    $display("test current trim done");
  endtask
  // Seeded average, saturation, unsigned ratio and both extremes
  task automatic t_temp();
    wr(8'h1a, 16'h807f);
    wr(8'h2d, 16'h0100);
    @(posedge clk) begin
      ratioVal <= 16'h1000;
      tempMeasureEnable <= 1'b1;
      lag <= 4'h9;
    end
    waitPulse(1'b1);
    check({15'h0, thermistorBiasPin}, 16'h0000);
    rdchk(8'h27, 16'h1000);
    rdchk(8'h08, trimx({1'b0, 16'h1000}, 16'h4000, 16'h0100));
    rdchk(8'h16, 16'h1200);
    rdchk(8'h1a, 16'h1212);
    @(posedge clk) ratioVal <= 16'hc000;
    waitPulse(1'b1);
    rdchk(8'h08, 16'h7fff);
    rdchk(8'h16, 16'h18df);
    rdchk(8'h1a, 16'h7f12);
    wr(8'h2c, 16'hc000);
    @(posedge clk) ratioVal <= 16'h1000;
    waitPulse(1'b1);
    rdchk(8'h08, 16'hf200);
    rdchk(8'h1a, 16'h7ff2);
    @(posedge clk) thermistorForceOn <= 1'b1;
    @(posedge clk) #1 check({15'h0, thermistorBiasPin}, 16'h0001);
    $display("test temperature done");
  endtask
  // Host temperature survives conversions; ratio still updates
  task automatic t_ext();
    @(posedge clk) begin
      extTempMode <= 1'b1;
      thermistorForceOn <= 1'b0;
      thermistorSwitchEnable <= 1'b0;
      ratioVal <= 16'h0800;
      lag <= 4'h0;
    end
    wr(8'h1a, 16'h807f);
    wr(8'h08, 16'h0a55);
    waitPulse(1'b1);
    // Switch enable clear: the pullup must stay on after the sample
    check({15'h0, thermistorBiasPin}, 16'h0001);
    rdchk(8'h08, 16'h0a55);
    rdchk(8'h1a, 16'h0a0a);
    rdchk(8'h27, 16'h0800);
    rdchk(8'h0c, 16'h0000);
    wr(8'h27, 16'h1357);
    rdchk(8'h27, 16'h0800);
    $display("test external mode done");
  endtask
  // Shutdown freezes conversions and keeps the ratio and temperature values
  task automatic t_shutdown();
    @(posedge clk) begin
      activeMode <= 1'b0;
      extTempMode <= 1'b0;
      ratioVal <= 16'h0400;
    end
    repeat (450) @(posedge clk);
    rdchk(8'h27, 16'h0800);
    rdchk(8'h08, 16'h0a55);
    $display("test shutdown done");
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_current();
    t_temp();
    t_ext();
    t_shutdown();
    results();
  end
  // Whole run needs about 1500 cycles
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule // tb
